// File: hw/tbdc_cfg.svh
/*
 * Register offsets, field positions, reset values and constants of the
 * ten-bit converter control block.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef TBDC_CFG_SVH
`define TBDC_CFG_SVH

`define TBDC_OFS_CONTROL 12'h000
`define TBDC_OFS_CODE 12'h004
`define TBDC_OFS_STATUS 12'h008
`define TBDC_OFS_POWER 12'h00c

`define TBDC_BIT_MODULE_ON 15
`define TBDC_BIT_IDLE_STOP 13
`define TBDC_BIT_SLEEP_KEEP 12
`define TBDC_BIT_JUSTIFY 11
`define TBDC_BIT_TRIG_EN 8
`define TBDC_BIT_PIN_DRIVE 7
`define TBDC_TSEL_HI 6
`define TBDC_TSEL_LO 2
`define TBDC_REF_HI 1
`define TBDC_REF_LO 0

`define TBDC_CONTROL_WMASK 16'hb9ff
`define TBDC_CONTROL_RESET 16'h0000
`define TBDC_CODE_RESET 16'h0000
`define TBDC_CODE_FULL_SCALE 1024
`define TBDC_TSEL_LAST 5'h11
`define TBDC_TSEL_HOLE 5'h09
`define TBDC_NUM_TRIG 18

`endif

// File: hw/tbdc_core.sv
/*
 * Converter core: justification, trigger selection, update holding and
 * power state of the ten-bit converter.
 * Assumes trigger inputs are one-cycle pulses synchronous to the clock.
 */
`include "tbdc_cfg.svh"
`default_nettype none

module tbdc_core (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register side
    tbdc_reg_if.core rif,
    // System state and trigger events
    input wire logic idle_mode,
    input wire logic sleep_mode,
    input wire logic [`TBDC_NUM_TRIG-1:0] trig_events
);
    logic [15:0] ctl;
    logic [4:0] tsel;
    logic trig_hit;
    logic halted;
    tbdc_pkg::tbdc_code_t pend_code;
    tbdc_pkg::tbdc_code_t active_r;
    tbdc_pkg::tbdc_code_t active_nxt;
    tbdc_pkg::tbdc_state_e state_r;
    tbdc_pkg::tbdc_state_e state_nxt;

    function automatic tbdc_pkg::tbdc_code_t justify(input logic [15:0] d, input logic left);
        justify = left ? d[15:6] : d[9:0];
    endfunction : justify

    assign ctl = rif.control;
    assign tsel = ctl[`TBDC_TSEL_HI:`TBDC_TSEL_LO];
    // Codes 01001 and above 10001 map to no source and never fire.
    assign trig_hit = (tsel <= `TBDC_TSEL_LAST) && (tsel != `TBDC_TSEL_HOLE)
                      && trig_events[tsel]; // [R8] [R9]
    assign halted = (idle_mode && ctl[`TBDC_BIT_IDLE_STOP]) // [R3]
                    || (sleep_mode && !ctl[`TBDC_BIT_SLEEP_KEEP]); // [R4]
    assign pend_code = justify(rif.code, ctl[`TBDC_BIT_JUSTIFY]); // [R5]

    always_comb begin
        state_nxt = tbdc_pkg::TBDC_ST_RUN;
        if (!ctl[`TBDC_BIT_MODULE_ON]) begin // [R2]
            state_nxt = tbdc_pkg::TBDC_ST_OFF;
        end else if (halted) begin
            state_nxt = tbdc_pkg::TBDC_ST_HALT;
        end
    end

    // The written code waits in the data register until the update event.
    always_comb begin
        active_nxt = active_r;
        if (state_r == tbdc_pkg::TBDC_ST_RUN) begin
            if (ctl[`TBDC_BIT_TRIG_EN]) begin
                if (trig_hit) begin
                    active_nxt = pend_code; // [R6] [R14]
                end
            end else if (rif.code_wr) begin
                active_nxt = pend_code; // [R6]
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= tbdc_pkg::TBDC_ST_OFF;
            active_r <= 10'h000;
        end else begin
            state_r <= state_nxt;
            active_r <= active_nxt;
        end
    end

    assign rif.state = state_r;
    assign rif.active_code = active_r;
endmodule : tbdc_core

`default_nettype wire

// File: hw/tbdc_pkg.sv
/*
 * Types shared by the converter control block.
 * Assumes the configuration header is compiled alongside.
 */
`default_nettype none

package tbdc_pkg;
    typedef enum logic [1:0] {
        TBDC_REF_NONE = 2'b00,
        TBDC_REF_EXT = 2'b01,
        TBDC_REF_SUPPLY = 2'b10,
        TBDC_REF_BANDGAP2X = 2'b11
    } tbdc_ref_e;

    typedef enum logic [1:0] {
        TBDC_ST_OFF = 2'b00,
        TBDC_ST_RUN = 2'b01,
        TBDC_ST_HALT = 2'b10
    } tbdc_state_e;

    typedef logic [9:0] tbdc_code_t;
endpackage : tbdc_pkg

`default_nettype wire

// File: hw/tbdc_reg_if.sv
/*
 * Carrier between the APB register slave and the converter core.
 * Assumes one clock domain shared by both ends.
 */
`default_nettype none

interface tbdc_reg_if;
    logic [15:0] control;
    logic [15:0] code;
    logic code_wr;
    tbdc_pkg::tbdc_state_e state;
    tbdc_pkg::tbdc_code_t active_code;

    modport regs (output control, output code, output code_wr,
                  input state, input active_code);
    modport core (input control, input code, input code_wr,
                  output state, output active_code);
endinterface : tbdc_reg_if

`default_nettype wire

// File: hw/tbdc_top.sv
/*
 * Ten-bit converter control block with its APB register slave.
 * Assumes an APB master on the same clock; the analog ladder and output
 * buffer sit outside and are steered by the outputs below.
 */
// Chosen here: the APB slave port and the address map.
//
// Function
// [R1] The analog output equals the chosen reference times the ten-bit code over 1024.
// [R2] Control bit 15 turns the converter module on when set and off when clear.
// [R3] With control bit 13 set the module stops in Idle, otherwise it keeps running.
// [R4] With bit 12 set the last value is kept in Sleep, otherwise it powers down and frees the pin.
// [R5] Bit 11 takes the code from data bits 15:6 when set and from bits 9:0 when clear.
// [R6] Bit 8 makes the output update on the chosen trigger, otherwise on each data write.
// [R7] Bit 7 drives the converter output onto its pin, otherwise the pin floats.
// [R8] Trigger codes 0-2 are comparators, 3 is conversion done, 4-8 timers, 9 is unused.
// [R9] Code 10 is the multi-output compare unit, 11-16 single units, 17 external interrupt one.
// [R10] Reference field 11 is twice band gap, 10 supply, 01 external pin, 00 disconnected.
// [R11] The band gap reference is requested whenever the module is enabled.
// [R12] Bits 14, 10 and 9 read as zero and all control bits reset to zero.
// [R13] Software sets the pin as an analog output through the port controls before use.
// [R14] In trigger mode the latest written code waits and loads at the first trigger pulse.
`include "tbdc_cfg.svh"
`default_nettype none

module tbdc_top (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // System power modes
    input wire logic IDLE_MODE,
    input wire logic SLEEP_MODE,
    // Trigger event pulses, indexed by source code
    input wire logic [`TBDC_NUM_TRIG-1:0] TRIG_EVENTS,
    // Converter analog front end
    output logic [9:0] CONV_CODE,
    output logic CONV_POWER_ON,
    output logic [1:0] CONV_REF_SELECT,
    output logic BANDGAP_REQUEST,
    output logic PIN_DRIVE_ON
);
    tbdc_reg_if rif ();

    logic [15:0] control_r;
    logic [15:0] control_nxt;
    logic [15:0] code_r;
    logic [15:0] code_nxt;
    logic code_wr_r;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic pslverr_r;
    logic ready_r;
    logic [9:0] conv_code_r;
    logic power_on_r;
    logic [1:0] ref_r;
    logic bandgap_r;
    logic pin_r;

    logic access;
    logic wr_en;
    logic rd_en;
    logic sel_control;
    logic sel_code;
    logic sel_status;
    logic sel_power;
    logic mapped;
    logic running;
    logic powered;
    logic [31:0] status_word;

    // Two-edge access phase: PREADY pulses high one cycle after the access starts, one wait state.
    assign access = PSEL && PENABLE;
    assign wr_en = access && PWRITE;
    assign rd_en = access && !PWRITE;
    assign sel_control = PADDR == `TBDC_OFS_CONTROL;
    assign sel_code = PADDR == `TBDC_OFS_CODE;
    assign sel_status = PADDR == `TBDC_OFS_STATUS;
    assign sel_power = PADDR == `TBDC_OFS_POWER;
    assign mapped = sel_control || sel_code || sel_status || sel_power;

    // Unimplemented bits are masked on write so they always read back zero.
    assign control_nxt = (wr_en && sel_control)
                         ? (PWDATA[15:0] & `TBDC_CONTROL_WMASK) : control_r; // [R12]
    assign code_nxt = (wr_en && sel_code) ? PWDATA[15:0] : code_r;

    assign running = rif.state == tbdc_pkg::TBDC_ST_RUN;
    // The ladder keeps its value in Sleep only while the sleep-keep bit is set.
    assign powered = running
                     || (rif.state == tbdc_pkg::TBDC_ST_HALT && control_r[`TBDC_BIT_SLEEP_KEEP]
                         && !(IDLE_MODE && control_r[`TBDC_BIT_IDLE_STOP])); // [R3] [R4]
    assign status_word = {20'h00000, rif.state, rif.active_code};

    assign prdata_nxt = !rd_en ? prdata_r
                      : sel_control ? {16'h0000, control_r}
                      : sel_code ? {16'h0000, code_r}
                      : sel_status ? status_word
                      : sel_power ? {27'h0000000, pin_r, bandgap_r, ref_r, power_on_r}
                      : 32'h00000000;

    assign rif.control = control_r;
    assign rif.code = code_r;
    assign rif.code_wr = code_wr_r;

    tbdc_core u_core (
        .clk(CORE_CLK),
        .rst(RST),
        .rif(rif),
        .idle_mode(IDLE_MODE),
        .sleep_mode(SLEEP_MODE),
        .trig_events(TRIG_EVENTS)
    );

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            control_r <= `TBDC_CONTROL_RESET; // [R12]
            code_r <= `TBDC_CODE_RESET;
            code_wr_r <= 1'b0;
            prdata_r <= 32'h00000000;
            pslverr_r <= 1'b0;
        end else begin
            control_r <= control_nxt;
            code_r <= code_nxt;
            code_wr_r <= wr_en && sel_code;
            prdata_r <= prdata_nxt;
            // Raised only on the first access edge so that it lines up with PREADY.
            pslverr_r <= access && !mapped && !ready_r;
        end
    end

    // Analog-facing outputs, all registered.
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            conv_code_r <= 10'h000;
            power_on_r <= 1'b0;
            ref_r <= 2'h0;
            bandgap_r <= 1'b0;
            pin_r <= 1'b0;
        end else begin
            conv_code_r <= rif.active_code; // [R1]
            power_on_r <= powered; // [R4]
            ref_r <= control_r[`TBDC_REF_HI:`TBDC_REF_LO]; // [R10]
            bandgap_r <= control_r[`TBDC_BIT_MODULE_ON]; // [R11]
            pin_r <= powered && control_r[`TBDC_BIT_PIN_DRIVE]; // [R7] [R4]
        end
    end

    // Read data and error are registered and appear one cycle after the start of the
    // access phase, so the slave inserts exactly one wait state.
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            ready_r <= 1'b0;
        end else begin
            ready_r <= access && !ready_r;
        end
    end

    assign PRDATA = prdata_r;
    assign PREADY = ready_r;
    assign PSLVERR = pslverr_r;
    assign CONV_CODE = conv_code_r;
    assign CONV_POWER_ON = power_on_r;
    assign CONV_REF_SELECT = ref_r;
    assign BANDGAP_REQUEST = bandgap_r;
    assign PIN_DRIVE_ON = pin_r;
endmodule : tbdc_top

`default_nettype wire

// File: verif/tb_top.sv
/* Self-checking bench for tbdc_top.
   Assumes the checker is bound from its own file. */
`include "tbdc_cfg.svh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic CORE_CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, er;
    logic IDLE_MODE, SLEEP_MODE, CONV_POWER_ON, BANDGAP_REQUEST, PIN_DRIVE_ON;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rd;
    logic [`TBDC_NUM_TRIG-1:0] TRIG_EVENTS;
    logic [9:0] CONV_CODE, cur;
    logic [1:0] CONV_REF_SELECT;
    logic [15:0] c, d;
    logic p;
    int n_errors = 0;
    int checks_done = 0;
    int seed = 99999;
    tbdc_top uut (.CORE_CLK(CORE_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .IDLE_MODE(IDLE_MODE), .SLEEP_MODE(SLEEP_MODE),
        .TRIG_EVENTS(TRIG_EVENTS), .CONV_CODE(CONV_CODE), .CONV_POWER_ON(CONV_POWER_ON),
        .CONV_REF_SELECT(CONV_REF_SELECT), .BANDGAP_REQUEST(BANDGAP_REQUEST),
        .PIN_DRIVE_ON(PIN_DRIVE_ON));
    initial begin
        CORE_CLK = 1'b0;
        forever #12.5 CORE_CLK = ~CORE_CLK;
    end
    function automatic logic [9:0] just(input logic [15:0] v, input logic l);
        return l ? v[15:6] : v[9:0];
    endfunction : just
    task automatic print_verdict;
        if (n_errors == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input string s, input logic [31:0] g, input logic [31:0] x);
        checks_done++;
        if (g !== x) begin
            n_errors++;
            $display("Error %s expected %h seen %h", s, x, g);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge CORE_CLK);
    endtask : step
    // An idle cycle before each setup keeps two transfers from touching one edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
        @(posedge CORE_CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= v;
        @(posedge CORE_CLK);
        PENABLE <= 1'b1;
        // Only the watchdog ends a wait that never sees PREADY.
        @(posedge CORE_CLK);
        while (PREADY !== 1'b1) begin
            @(posedge CORE_CLK);
        end
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb
    task automatic ctl(input logic [15:0] v);
        apb(1'b1, 12'h000, {16'h0, v});
        step(3);
        apb(1'b0, 12'h00c, 32'h0);
        chk("mirror", rd, {27'h0, v[7] & v[15], v[15], v[1:0], v[15]});
    endtask : ctl
    task automatic trig(input int t);
        @(posedge CORE_CLK);
        TRIG_EVENTS <= 18'h1 << t;
        @(posedge CORE_CLK);
        TRIG_EVENTS <= 18'h0;
        step(3);
    endtask : trig
    initial begin
        #200000;
        n_errors++;
        print_verdict();
    end
    initial begin
        {RST, PSEL, PENABLE, PWRITE, IDLE_MODE, SLEEP_MODE} = 6'h20;
        PADDR = 12'h0;
        PWDATA = 32'h0;
        TRIG_EVENTS = 18'h0;
        step(3);
        RST <= 1'b0;
        apb(1'b0, 12'h000, 32'h0);
        chk("control reset", rd, 32'h0);
        ctl(16'hffff);
        apb(1'b0, 12'h000, 32'h0);
        chk("control mask", rd, 32'h0000b9ff);
        apb(1'b1, 12'h010, 32'h0);
        chk("unmapped write", er, 1'b1);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped read error", {31'h0, er}, 32'h1);
        chk("unmapped read data", rd, 32'h0);
        for (int i = 0; i < 12; i++) begin
            c = 16'h8080 | (i[0] << 11) | ($random(seed) & 3);
            d = (i < 2) ? 16'hffff : 16'($random(seed));
            ctl(c);
            apb(1'b1, 12'h004, {16'h0, d});
            step(4);
            cur = just(d, c[11]);
            chk("immediate code", CONV_CODE, cur);
            apb(1'b0, 12'h008, 32'h0);
            chk("status", rd, {20'h0, 2'h1, cur});
        end
        for (int t = 0; t < 18; t++) begin
            c = 16'h8103 | (t << 2) | (t[0] << 11);
            ctl(c);
            d = 16'($random(seed));
            apb(1'b1, 12'h004, {16'h0, d});
            step(4);
            chk("pending held", CONV_CODE, cur);
            trig((t + 1) % 18);
            chk("other trigger", CONV_CODE, cur);
            trig(t);
            cur = (t == 9) ? cur : just(d, c[11]);
            chk("trigger code", CONV_CODE, cur);
        end
        for (int i = 0; i < 4; i++) begin
            ctl(16'h8082 | (i[0] ? 16'h3000 : 16'h0));
            IDLE_MODE <= !i[1];
            SLEEP_MODE <= i[1];
            step(6);
            p = i[1] ? i[0] : !i[0];
            chk("power in mode", CONV_POWER_ON, p);
            chk("pin in mode", PIN_DRIVE_ON, p);
            IDLE_MODE <= 1'b0;
            SLEEP_MODE <= 1'b0;
            step(3);
        end
        // A second reset in mid-run must clear the control register again.
        RST <= 1'b1;
        step(2);
        RST <= 1'b0;
        apb(1'b0, 12'h000, 32'h0);
        chk("control mid reset", rd, 32'h0);
        ctl(16'h0);
        chk("power off", CONV_POWER_ON, 1'b0);
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire

// File: verif/tbdc_props.sv
/* Checker for tbdc_top.
   Assumes one clock and the one-wait-state APB slave. */
`include "tbdc_cfg.svh"
`default_nettype none
module tbdc_props (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST,
    // APB
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // Modes and triggers
    input wire logic IDLE_MODE,
    input wire logic SLEEP_MODE,
    input wire logic [`TBDC_NUM_TRIG-1:0] TRIG_EVENTS,
    // Front end
    input wire logic [9:0] CONV_CODE,
    input wire logic CONV_POWER_ON,
    input wire logic [1:0] CONV_REF_SELECT,
    input wire logic BANDGAP_REQUEST,
    input wire logic PIN_DRIVE_ON
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RST);
    // A held access is seen on two edges, so a code write may land from either.
    wire code_wr = PSEL && PENABLE && PWRITE && PADDR == 12'h004;
    wire ctl_wr = PSEL && PENABLE && PWRITE && PADDR == 12'h000;
    wire any_trig = |TRIG_EVENTS;
    wire [1:0] ref_in = PWDATA[1:0];
    wire en_in = PWDATA[15];
    sequence s_wait;
        PSEL && PENABLE && !PREADY;
    endsequence
    a_ready_late: assert property (s_wait |=> PREADY) else $error("ready late");
    a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready held");
    a_err_ready: assert property (PSLVERR |-> PREADY) else $error("error without ready");
    a_err_zero: assert property (PSLVERR && !PWRITE |-> PRDATA == 32'h0)
        else $error("error read not zero");
    a_ctl_copy: assert property (ctl_wr |-> ##2 (CONV_REF_SELECT == $past(ref_in, 2)
        && BANDGAP_REQUEST == $past(en_in, 2))) else $error("control copy wrong");
    a_pin_power: assert property ($rose(PIN_DRIVE_ON) |-> CONV_POWER_ON)
        else $error("pin driven unpowered");
    a_power_enable: assert property ($rose(CONV_POWER_ON) |-> BANDGAP_REQUEST)
        else $error("powered while disabled");
    a_sleep_frozen: assert property (SLEEP_MODE [*5] |-> $stable(CONV_CODE))
        else $error("code moved in sleep");
    a_code_cause: assert property ($changed(CONV_CODE) |-> $past(code_wr, 3)
        || $past(code_wr, 4) || $past(any_trig, 2)) else $error("code moved without cause");
endmodule : tbdc_props
bind tbdc_top tbdc_props u_props (.CORE_CLK(CORE_CLK), .RST(RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .IDLE_MODE(IDLE_MODE), .SLEEP_MODE(SLEEP_MODE),
    .TRIG_EVENTS(TRIG_EVENTS), .CONV_CODE(CONV_CODE), .CONV_POWER_ON(CONV_POWER_ON),
    .CONV_REF_SELECT(CONV_REF_SELECT), .BANDGAP_REQUEST(BANDGAP_REQUEST),
    .PIN_DRIVE_ON(PIN_DRIVE_ON));
`default_nettype wire
